/* rcp_pkg.sv */
// Purpose: shared constants for the serial command port
// Assumes: 125 MHz system clock
// Notes:   rate codes select the bit period; error codes are reported to firmware
package rcp_pkg;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ      = 125_000_000;
	localparam int unsigned BAUD_LOW    = 9600;
	localparam int unsigned BAUD_MID    = 19200;
	localparam int unsigned BAUD_HIGH   = 38400;
	localparam int unsigned DIV_LOW     = CLK_HZ / BAUD_LOW;
	localparam int unsigned DIV_MID     = CLK_HZ / BAUD_MID;
	localparam int unsigned DIV_HIGH    = CLK_HZ / BAUD_HIGH;
	localparam int unsigned DIV_W       = 14;
	// ------------------------------------------------------------
	// frame
	// ------------------------------------------------------------
	localparam int unsigned DATA_BITS   = 8;
	localparam int unsigned STOP_BITS   = 1;
	// ------------------------------------------------------------
	// rate select codes
	// ------------------------------------------------------------
	localparam logic [1:0]  RATE_9600   = 2'h0;
	localparam logic [1:0]  RATE_19200  = 2'h1;
	localparam logic [1:0]  RATE_38400  = 2'h2;
	// ------------------------------------------------------------
	// error codes
	// ------------------------------------------------------------
	localparam logic [9:0]  ERR_NONE    = 10'h000;
	localparam logic [9:0]  ERR_BREAK   = 10'h168;
	localparam logic [9:0]  ERR_FRAMING = 10'h16a;
	localparam logic [9:0]  ERR_OVERRUN = 10'h16b;
endpackage

/* rcp_tx.sv */
// Purpose: serial transmitter, start, 8 data lsb first, one stop
// Assumes: bit_div stable while busy
// Notes:   line idles high
`timescale 1ns/1ps
module rcp_tx
(
	input  wire logic                      clock,
	input  wire logic                      rst_b,
	input  wire logic [rcp_pkg::DIV_W-1:0] bit_div,
	input  wire logic                      tx_valid,
	input  wire logic [7:0]                tx_data,
	output logic                           tx_ready,
	output logic                           txd
);
	logic [rcp_pkg::DIV_W-1:0] cnt_q, cnt_d;
	logic [3:0]                idx_q, idx_d;
	logic [9:0]                sh_q, sh_d;
	logic                      busy_q, busy_d;
	logic                      txd_q, txd_d;

	assign tx_ready = !busy_q;
	assign txd      = txd_q;

	// ------------------------------------------------------------
	// shifter
	// ------------------------------------------------------------
	// frame of start, data, stop shifted out lsb first
	always_comb
	begin
		cnt_d  = cnt_q;
		idx_d  = idx_q;
		sh_d   = sh_q;
		busy_d = busy_q;
		txd_d  = txd_q;
		if (!busy_q)
		begin
			txd_d = 1'b1;
			if (tx_valid)
			begin
				sh_d   = {1'b1, tx_data, 1'b0};
				busy_d = 1'b1;
				cnt_d  = '0;
				idx_d  = 4'h0;
				txd_d  = 1'b0;
			end
		end
		else if (cnt_q == bit_div - 1'b1)
		begin
			cnt_d = '0;
			if (idx_q == 4'h9)
			begin
				busy_d = 1'b0;
				txd_d  = 1'b1;
			end
			else
			begin
				idx_d = idx_q + 4'h1;
				txd_d = sh_q[idx_q + 4'h1];
			end
		end
		else
			cnt_d = cnt_q + 1'b1;
	end

	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			cnt_q  <= '0;
			idx_q  <= 4'h0;
			sh_q   <= 10'h3ff;
			busy_q <= 1'b0;
			txd_q  <= 1'b1;
		end
		else
		begin
			cnt_q  <= cnt_d;
			idx_q  <= idx_d;
			sh_q   <= sh_d;
			busy_q <= busy_d;
			txd_q  <= txd_d;
		end
	end

	property p_tx_start;
		@(posedge clock) disable iff (!rst_b)
		(tx_ready && tx_valid) |=> (txd == 1'b0) && !tx_ready;
	endproperty
	a_tx_start: assert property (p_tx_start) else $error("start bit not driven low");

	property p_tx_idle;
		@(posedge clock) disable iff (!rst_b)
		(tx_ready && !tx_valid) |=> txd;
	endproperty
	a_tx_idle: assert property (p_tx_idle) else $error("line not idle high");
endmodule

/* rcp_port.sv */
// Purpose: serial command port top, wired as terminal equipment
// Assumes: rxd synchronous to clock; partner uses the selected rate
// Notes:   no flow control; modem inputs are ignored
//
// Summary of operation
// - the port offers 9600, 19200 and 38400 bit/s and uses the chosen rate both ways.
// - each character is eight data bits and one stop bit with no parity.
// - terminal-ready and request-to-send outputs are held asserted at all times.
// - carrier-detect, set-ready, clear-to-send and ring inputs are ignored.
// - data leaves only on txd and enters only on rxd.
// - a character with a high stop bit arriving while the previous one is still untaken raises overrun code 363.
// - a stop bit found low after nonzero data raises framing code 362.
// - a break on the receive line raises communication code 360.
`timescale 1ns/1ps
module rcp_port
(
	input  wire logic       clock,
	input  wire logic       rst_b,
	input  wire logic [1:0] rate_sel,
	input  wire logic       rxd,
	output logic            txd,
	output logic            dtr,
	output logic            rts,
	input  wire logic       dcd,
	input  wire logic       dsr,
	input  wire logic       cts,
	input  wire logic       ri,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	output logic            tx_ready,
	output logic            rx_valid,
	output logic [7:0]      rx_data,
	input  wire logic       rx_ready,
	output logic            err_valid,
	output logic [9:0]      err_code
);
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rcp_rx_e;

	logic [rcp_pkg::DIV_W-1:0] bit_div;
	rcp_rx_e                   st_q, st_d;
	logic [rcp_pkg::DIV_W-1:0] cnt_q, cnt_d;
	logic [2:0]                bit_q, bit_d;
	logic [7:0]                sh_q, sh_d;
	logic [7:0]                dat_q, dat_d;
	logic                      full_q, full_d;
	logic                      ev_q, ev_d;
	logic [9:0]                code_q, code_d;
	logic                      brk_q, brk_d;
	logic                      unused_modem;

	// ------------------------------------------------------------
	// rate and static pins
	// ------------------------------------------------------------
	// unknown codes fall back to the slowest rate rather than stalling
	always_comb
	begin
		unique case (rate_sel)
			rcp_pkg::RATE_19200: bit_div = rcp_pkg::DIV_W'(rcp_pkg::DIV_MID);
			rcp_pkg::RATE_38400: bit_div = rcp_pkg::DIV_W'(rcp_pkg::DIV_HIGH);
			default:             bit_div = rcp_pkg::DIV_W'(rcp_pkg::DIV_LOW);
		endcase
	end

	assign dtr          = 1'b1;
	assign rts          = 1'b1;
	assign unused_modem = dcd ^ dsr ^ cts ^ ri;
	assign rx_valid     = full_q;
	assign rx_data      = dat_q;
	assign err_valid    = ev_q;
	assign err_code     = code_q;

	// ------------------------------------------------------------
	// transmitter
	// ------------------------------------------------------------
	rcp_tx u_tx
	(
		.clock    (clock),
		.rst_b    (rst_b),
		.bit_div  (bit_div),
		.tx_valid (tx_valid),
		.tx_data  (tx_data),
		.tx_ready (tx_ready),
		.txd      (txd)
	);

	// ------------------------------------------------------------
	// receiver
	// ------------------------------------------------------------
	// samples mid-bit; any low stop (break or framing) waits for high line before rearming
	always_comb
	begin
		st_d   = st_q;
		cnt_d  = cnt_q + 1'b1;
		bit_d  = bit_q;
		sh_d   = sh_q;
		dat_d  = dat_q;
		full_d = full_q && !rx_ready;
		ev_d   = 1'b0;
		code_d = code_q;
		brk_d  = brk_q && !rxd;
		unique case (st_q)
			RX_IDLE:
			begin
				cnt_d = '0;
				if (!rxd && !brk_q)
					st_d = RX_START;
			end
			RX_START:
				if (cnt_q == (bit_div >> 1))
				begin
					cnt_d = '0;
					st_d  = rxd ? RX_IDLE : RX_DATA; // glitch rejected
					bit_d = 3'h0;
				end
			RX_DATA:
				if (cnt_q == bit_div - 1'b1)
				begin
					cnt_d = '0;
					sh_d  = {rxd, sh_q[7:1]};
					bit_d = bit_q + 3'h1;
					if (bit_q == 3'h7)
						st_d = RX_STOP;
				end
			RX_STOP:
				if (cnt_q == bit_div - 1'b1)
				begin
					st_d = RX_IDLE;
					if (!rxd)
					begin
						ev_d   = 1'b1;
						code_d = (sh_q == 8'h00) ? rcp_pkg::ERR_BREAK : rcp_pkg::ERR_FRAMING;
						brk_d  = 1'b1;
					end
					else if (full_q && !rx_ready)
					begin
						ev_d   = 1'b1;
						code_d = rcp_pkg::ERR_OVERRUN;
					end
					else
					begin
						dat_d  = sh_q;
						full_d = 1'b1;
					end
				end
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			st_q   <= RX_IDLE;
			cnt_q  <= '0;
			bit_q  <= 3'h0;
			sh_q   <= 8'h00;
			dat_q  <= 8'h00;
			full_q <= 1'b0;
			ev_q   <= 1'b0;
			code_q <= rcp_pkg::ERR_NONE;
			brk_q  <= 1'b0;
		end
		else
		begin
			st_q   <= st_d;
			cnt_q  <= cnt_d;
			bit_q  <= bit_d;
			sh_q   <= sh_d;
			dat_q  <= dat_d;
			full_q <= full_d;
			ev_q   <= ev_d;
			code_q <= code_d;
			brk_q  <= brk_d;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_handshake_fixed;
		@(posedge clock) disable iff (!rst_b)
		dtr && rts;
	endproperty
	a_handshake_fixed: assert property (p_handshake_fixed) else $error("handshake not asserted");

	sequence s_stop_low;
		(st_q == RX_STOP) && (cnt_q == bit_div - 1'b1) && !rxd;
	endsequence

	property p_framing;
		@(posedge clock) disable iff (!rst_b)
		(s_stop_low and (sh_q != 8'h00)) |=> err_valid && (err_code == rcp_pkg::ERR_FRAMING);
	endproperty
	a_framing: assert property (p_framing) else $error("framing code missing");

	property p_break;
		@(posedge clock) disable iff (!rst_b)
		(s_stop_low and (sh_q == 8'h00)) |=> err_valid && (err_code == rcp_pkg::ERR_BREAK);
	endproperty
	a_break: assert property (p_break) else $error("break code missing");

	// a held-low line after a bad stop must not be taken as a stream of new start bits
	property p_break_rearm;
		@(posedge clock) disable iff (!rst_b)
		brk_q && !rxd |=> (st_q == RX_IDLE);
	endproperty
	a_break_rearm: assert property (p_break_rearm) else $error("receiver rearmed while line held low");

	property p_overrun;
		@(posedge clock) disable iff (!rst_b)
		(st_q == RX_STOP) && (cnt_q == bit_div - 1'b1) && rxd && rx_valid && !rx_ready
			|=> err_valid && (err_code == rcp_pkg::ERR_OVERRUN) && $stable(rx_data);
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun code missing");

	property p_rate;
		@(posedge clock) disable iff (!rst_b)
		(rate_sel == rcp_pkg::RATE_38400) |-> (bit_div == rcp_pkg::DIV_W'(rcp_pkg::DIV_HIGH));
	endproperty
	a_rate: assert property (p_rate) else $error("wrong divider for fast rate");

	property p_rx_hold;
		@(posedge clock) disable iff (!rst_b)
		rx_valid && !rx_ready |=> rx_valid && $stable(rx_data);
	endproperty
	a_rx_hold: assert property (p_rx_hold) else $error("received byte dropped");
endmodule

/* rcp_peer.sv */
// Purpose: computer side of the serial link
// Assumes: bit_div set to the port's rate before a frame
// Notes:   line idles high like a marking rs232 line
`timescale 1ns/1ps
module rcp_peer
(
	input  wire logic        clock,
	input  wire logic [13:0] bit_div,
	input  wire logic        txd,
	output logic             rxd,
	output logic [7:0]       got_data,
	output logic             got_stop,
	output logic [31:0]      got_len,
	output logic [31:0]      n_got
);
	logic [31:0] run = 32'h0;
	initial
	begin
		rxd = 1'b1;
		n_got = 32'h0;
		got_len = 32'h0;
	end
	// send one frame; stop may be driven low on purpose
	task automatic send_frame(input logic [7:0] d, input logic stop);
		rxd <= 1'b0;
		repeat (bit_div) @(posedge clock);
		for (int i = 0; i < 8; i++)
		begin
			rxd <= d[i];
			repeat (bit_div) @(posedge clock);
		end
		rxd <= stop;
		repeat (bit_div) @(posedge clock);
		rxd <= 1'b1;
		repeat (bit_div) @(posedge clock);
	endtask
	// length of the latest low run on txd (start or data bits), kept apart so an aborted frame still counts
	always @(posedge clock)
		if (txd === 1'b0)
			run <= run + 32'h1;
		else if (run != 32'h0)
		begin
			got_len <= run;
			run <= 32'h0;
		end
	// mid-bit sampling of what the port sends
	always
	begin
		@(negedge txd);
		repeat (bit_div) @(posedge clock);
		repeat (bit_div / 2) @(posedge clock);
		for (int i = 0; i < 8; i++)
		begin
			got_data[i] = txd;
			repeat (bit_div) @(posedge clock);
		end
		got_stop = txd;
		n_got = n_got + 32'h1;
	end
endmodule

/* tb.sv */
// Purpose: self-checking bench for the serial command port
// Assumes: design checks its own assertions
// Notes:   rx frames use the top rate to keep the run short
`timescale 1ns/1ps
module tb;
	logic        clock = 1'b0;
	logic        rst_b = 1'b0;
	logic [1:0]  rate_sel = rcp_pkg::RATE_38400;
	logic [13:0] div = 14'(rcp_pkg::DIV_HIGH);
	logic [3:0]  modem = 4'h0;
	logic        tx_valid = 1'b0;
	logic [7:0]  tx_data = 8'h00;
	logic        rx_ready = 1'b0;
	logic        rxd, txd, dtr, rts, tx_ready, rx_valid, err_valid, got_stop;
	logic [7:0]  rx_data, got_data;
	logic [9:0]  err_code;
	logic [9:0]  err_seen = 10'h000;
	logic [31:0] got_len, n_got;
	int          mismatches = 0;
	int          n_tests = 0;
	int          n_err = 0;
	always #4 clock = ~clock;
	// modem inputs keep toggling; the port must not care
	always @(posedge clock) modem <= modem + 4'h1;
	// latch each error pulse
	always @(posedge clock)
		if (err_valid === 1'b1)
		begin
			err_seen <= err_code;
			n_err <= n_err + 1;
		end
	rcp_port dut_u
	(
		.clock(clock), .rst_b(rst_b), .rate_sel(rate_sel), .rxd(rxd), .txd(txd),
		.dtr(dtr), .rts(rts), .dcd(modem[0]), .dsr(modem[1]), .cts(modem[2]), .ri(modem[3]),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_ready(rx_ready), .err_valid(err_valid), .err_code(err_code)
	);
	rcp_peer peer_u
	(
		.clock(clock), .bit_div(div), .txd(txd), .rxd(rxd), .got_data(got_data),
		.got_stop(got_stop), .got_len(got_len), .n_got(n_got)
	);
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic do_reset;
		rst_b <= 1'b0;
		repeat (16) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
	endtask
	// transmitter is idle here, so one edge takes the byte
	task automatic tx_send(input logic [7:0] d);
		check(tx_ready, 32'h1);
		tx_valid <= 1'b1;
		tx_data <= d;
		@(posedge clock);
		tx_valid <= 1'b0;
	endtask
	// both directions at once, byte left untaken
	task automatic t_duplex;
		fork
			tx_send(8'ha5);
			peer_u.send_frame(8'h3c, 1'b1);
		join
		check(n_got, 32'h1);
		check(got_data, 8'ha5);
		check(got_stop, 1'b1);
		check(got_len, 32'(rcp_pkg::DIV_HIGH));
		check(rx_valid, 1'b1);
		check(rx_data, 8'h3c);
		check({dtr, rts}, 2'h3);
		check(tx_ready, 1'b1);
	endtask
	task automatic t_rx_errors;
		peer_u.send_frame(8'h81, 1'b1);
		check(err_seen, rcp_pkg::ERR_OVERRUN);
		check(rx_data, 8'h3c);
		rx_ready <= 1'b1;
		@(posedge clock);
		rx_ready <= 1'b0;
		@(posedge clock);
		check(rx_valid, 1'b0);
		peer_u.send_frame(8'h55, 1'b0);
		check(err_seen, rcp_pkg::ERR_FRAMING);
		check(rx_valid, 1'b0);
		peer_u.send_frame(8'h00, 1'b0);
		check(err_seen, rcp_pkg::ERR_BREAK);
		check(n_err, 32'h3);
	endtask
	// slow rates: start bit length only, then the next call's reset or the final $finish cuts the frame short
	task automatic t_rate(input logic [1:0] code, input logic [13:0] d);
		rate_sel <= code;
		div <= d;
		do_reset();
		tx_send(8'h01);
		repeat (d + 8) @(posedge clock);
		check(got_len, 32'(d));
	endtask
	initial
	begin
		do_reset();
		t_duplex();
		t_rx_errors();
		t_rate(rcp_pkg::RATE_9600, 14'(rcp_pkg::DIV_LOW));
		t_rate(rcp_pkg::RATE_19200, 14'(rcp_pkg::DIV_MID));
		results();
	end
	initial
	begin
		repeat (200000) @(posedge clock);
		mismatches++;
		results();
	end
endmodule
